// file: common/rplk_pkg.sv
package rplk_pkg;
   // ----------------------------------------------------------------
   // clocking and serial rates
   // ----------------------------------------------------------------
   localparam int CLK_HZ     = 250_000_000;
   localparam int OVS        = 16;
   localparam int BAUD_1200  = 1200;
   localparam int BAUD_2400  = 2400;
   localparam int BAUD_9600  = 9600;
   localparam int BAUD_19200 = 19200;
   // oversample tick divisors, rounded down
   localparam int DIV_1200   = CLK_HZ / (OVS * BAUD_1200);
   localparam int DIV_2400   = CLK_HZ / (OVS * BAUD_2400);
   localparam int DIV_9600   = CLK_HZ / (OVS * BAUD_9600);
   localparam int DIV_19200  = CLK_HZ / (OVS * BAUD_19200);

   // ----------------------------------------------------------------
   // register map and fields
   // ----------------------------------------------------------------
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_ADDR = 8'h04;
   localparam logic [7:0] A_TX   = 8'h08;
   localparam logic [7:0] A_RX   = 8'h0c;
   localparam logic [7:0] A_STAT = 8'h10;
   localparam logic [7:0] A_LOCK = 8'h14;
   localparam logic [7:0] A_CAPS = 8'h18;
   localparam int C_BAUD = 0;
   localparam int C_EIGHT = 2;
   localparam int C_PAR = 3;
   localparam int C_TWO = 5;
   localparam logic [5:0] CTRL_RST = 6'h06;
   localparam logic [4:0] ADDR_RST = 5'h01;
   localparam int S_TXFULL = 0, S_RXV = 1, S_LF = 2, S_PAUSE = 3;
   localparam int S_OVR = 4, S_PERR = 5, S_FERR = 6, S_LLO = 7;
   localparam int S_KLK = 8, S_DOFF = 9, S_KBD = 10;
   localparam int L_KON = 0, L_KOFF = 1, L_DOFF = 2, L_DTXT = 3, L_DON = 4;
   // sh, ah, talker, listener, srq, remote-local, clear; no pp/dt/ctl
   localparam logic [9:0] CAPS_VAL = 10'h07f;
   localparam logic [1:0] PAR_NONE = 2'h0;
   localparam logic [1:0] PAR_EVEN = 2'h1;
   localparam logic [1:0] PAR_ODD  = 2'h2;
   localparam logic [7:0] CH_LF    = 8'h0a;
   localparam logic [7:0] CH_XON   = 8'h11;
   localparam logic [7:0] CH_XOFF  = 8'h13;
   localparam logic [7:0] CH_SP    = 8'h20;
   localparam logic [7:0] CH_DEL   = 8'h7f;

   typedef enum logic [4:0] {
      ST_IDLE  = 5'h01,
      ST_START = 5'h02,
      ST_DATA  = 5'h04,
      ST_PAR   = 5'h08,
      ST_STOP  = 5'h10
   } rplk_ser_st_t;

   function automatic logic rplk_par(input logic [7:0] d,
                                     input logic eight,
                                     input logic odd);
      rplk_par = ^(eight ? d : {1'b0, d[6:0]}) ^ odd;
   endfunction
endpackage

// file: core/rplk_rx.sv
`timescale 1ns/1ps
module rplk_rx (
   input  wire logic       clk_i,    // core clock
   input  wire logic       rst_i,    // sync reset
   input  wire logic       tick_i,   // 16x bit tick
   input  wire logic       rxd_i,    // raw serial pin
   input  wire logic       eight_i,  // 8 data bits
   input  wire logic [1:0] par_i,    // parity mode
   output logic [7:0]      data_o,   // received char
   output logic            vld_o,    // char pulse
   output logic            perr_o,   // parity error pulse
   output logic            ferr_o    // framing error pulse
);
   logic rx_m_r, rx_s_r;
   rplk_pkg::rplk_ser_st_t st_r, st_nxt;
   logic [3:0] sub_r, sub_nxt;
   logic [2:0] bit_r, bit_nxt;
   logic [7:0] sh_r, sh_nxt;
   logic perr_r, perr_nxt, vld_nxt, ferr_nxt, pe_nxt;
   logic [7:0] dat_nxt;

   always_comb begin
      st_nxt = st_r;
      sub_nxt = sub_r;
      bit_nxt = bit_r;
      sh_nxt = sh_r;
      perr_nxt = perr_r;
      vld_nxt = 1'b0;
      ferr_nxt = 1'b0;
      pe_nxt = 1'b0;
      dat_nxt = data_o;
      if (tick_i) begin
         sub_nxt = sub_r + 4'h1;
         case (st_r)
            rplk_pkg::ST_IDLE: begin
               sub_nxt = 4'h0;
               if (!rx_s_r) st_nxt = rplk_pkg::ST_START;
            end
            rplk_pkg::ST_START: begin
               // mid-bit recheck rejects glitches
               if (sub_r == 4'h7) begin
                  sub_nxt = 4'h0;
                  bit_nxt = 3'h0;
                  perr_nxt = 1'b0;
                  st_nxt = rx_s_r ? rplk_pkg::ST_IDLE : rplk_pkg::ST_DATA;
               end
            end
            rplk_pkg::ST_DATA: begin
               if (sub_r == 4'hf) begin
                  sh_nxt = {rx_s_r, sh_r[7:1]};
                  bit_nxt = bit_r + 3'h1;
                  if (bit_r == (eight_i ? 3'h7 : 3'h6)) begin
                     if (!eight_i) sh_nxt = {1'b0, rx_s_r, sh_r[7:2]};
                     st_nxt = (par_i == rplk_pkg::PAR_NONE) ?
                              rplk_pkg::ST_STOP : rplk_pkg::ST_PAR;
                  end
               end
            end
            rplk_pkg::ST_PAR: begin
               if (sub_r == 4'hf) begin
                  perr_nxt = rx_s_r != rplk_pkg::rplk_par(sh_r, eight_i,
                                 par_i == rplk_pkg::PAR_ODD);
                  st_nxt = rplk_pkg::ST_STOP;
               end
            end
            rplk_pkg::ST_STOP: begin
               // only the first stop bit is checked
               if (sub_r == 4'hf) begin
                  vld_nxt = rx_s_r & ~perr_r;
                  pe_nxt = rx_s_r & perr_r;
                  ferr_nxt = ~rx_s_r;
                  dat_nxt = sh_r;
                  st_nxt = rplk_pkg::ST_IDLE;
               end
            end
            default: st_nxt = rplk_pkg::ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      rx_m_r <= rxd_i;
      rx_s_r <= rx_m_r;
      if (rst_i) begin
         st_r <= rplk_pkg::ST_IDLE;
         sub_r <= 4'h0;
         bit_r <= 3'h0;
         sh_r <= 8'h00;
         perr_r <= 1'b0;
         data_o <= 8'h00;
         vld_o <= 1'b0;
         perr_o <= 1'b0;
         ferr_o <= 1'b0;
      end else begin
         st_r <= st_nxt;
         sub_r <= sub_nxt;
         bit_r <= bit_nxt;
         sh_r <= sh_nxt;
         perr_r <= perr_nxt;
         data_o <= dat_nxt;
         vld_o <= vld_nxt;
         perr_o <= pe_nxt;
         ferr_o <= ferr_nxt;
      end
   end
endmodule // rplk_rx

// file: core/rplk_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// - four selectable rates, 1200 to 19200 baud
// - 7/8 data, even/odd/no parity, 1/2 stops
// - point to point, no instrument addressing
// - pins: rxd in; txd, rts out
// - serial chars feed same command path
// - bus functions sh ah t l sr rl dc
// - no parallel poll, trigger or controller
// - bus address from local register setting
// - powers up local, nothing locked
// - remote mode alone never locks panel
// - llo locks keyboard; gtl or ren-off release
// - bus lockout unreachable from serial port
// - klock on locks until klock off
// - display off or text blanks and locks
// - display on restores display, and keyboard unless llo or klock holds it
// - power cycle clears every lockout
// - line feed ends messages; xon/xoff pause tx; other controls ignored
module rplk_top #(
   parameter int DIV_1200  = rplk_pkg::DIV_1200,
   parameter int DIV_2400  = rplk_pkg::DIV_2400,
   parameter int DIV_9600  = rplk_pkg::DIV_9600,
   parameter int DIV_19200 = rplk_pkg::DIV_19200
) (
   input  wire logic        clk_i,        // core clock
   input  wire logic        rst_i,        // sync reset, power-up
   input  wire logic        wb_cyc_i,     // wishbone cycle
   input  wire logic        wb_stb_i,     // wishbone strobe
   input  wire logic        wb_we_i,      // wishbone write
   input  wire logic [7:0]  wb_adr_i,     // byte address
   input  wire logic [3:0]  wb_sel_i,     // byte enables
   input  wire logic [31:0] wb_dat_i,     // write data
   output logic      [31:0] wb_dat_o,     // read data
   output logic             wb_ack_o,     // acknowledge
   input  wire logic        rxd_i,        // serial receive pin
   output logic             txd_o,        // serial transmit pin
   output logic             rts_o,        // request to send
   input  wire logic        bus_llo_i,    // lockout message pulse
   input  wire logic        bus_gtl_i,    // go-to-local pulse
   input  wire logic        bus_ren_i,    // remote enable level
   output logic      [4:0]  bus_addr_o,   // bus address
   output logic             kbd_lock_o,   // keyboard disabled
   output logic             disp_blank_o  // display blanked
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   logic        ack_nxt;
   logic [31:0] dat_nxt;
   logic [5:0]  ctrl_r, ctrl_nxt;
   logic [4:0]  addr_nxt;
   logic [15:0] div_cnt_r, div_cnt_nxt, div_max;
   logic        tick_r, tick_nxt;
   rplk_pkg::rplk_ser_st_t tx_st_r, tx_st_nxt;
   logic [3:0]  tx_sub_r, tx_sub_nxt;
   logic [2:0]  tx_bit_r, tx_bit_nxt;
   logic [7:0]  tx_sh_r, tx_sh_nxt, tx_hold_r, tx_hold_nxt;
   logic        tx_full_r, tx_full_nxt, tx_par_r, tx_par_nxt;
   logic        tx_stop_r, tx_stop_nxt, txd_nxt;
   logic [7:0]  rx_chr, rx_byte, rx_dat_r, rx_dat_nxt;
   logic        rx_vld, rx_perr, rx_ferr;
   logic        rxv_r, rxv_nxt, lf_r, lf_nxt, pause_r, pause_nxt;
   logic        ovr_r, ovr_nxt, perr_r, perr_nxt, ferr_r, ferr_nxt;
   logic        llo_r, llo_nxt, klk_r, klk_nxt, doff_r, doff_nxt;
   logic        wr, rd, is_ctl;
   logic [7:0]  wd;
   logic [10:0] stat;

   assign wr = wb_cyc_i & wb_stb_i & ~wb_ack_o & wb_we_i & wb_sel_i[0];
   assign rd = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_we_i;
   assign wd = wb_dat_i[7:0];
   assign stat = {kbd_lock_o, doff_r, klk_r, llo_r, ferr_r, perr_r,
                  ovr_r, pause_r, lf_r, rxv_r, tx_full_r};

   // ---------------------------------------------------------------
   // wishbone slave: ack one cycle after the strobe
   // ---------------------------------------------------------------
   always_comb begin
      ack_nxt = wb_cyc_i & wb_stb_i & ~wb_ack_o;
      dat_nxt = 32'h0000_0000;
      ctrl_nxt = ctrl_r;
      addr_nxt = bus_addr_o;
      if (rd) begin
         case (wb_adr_i)
            rplk_pkg::A_CTRL: dat_nxt = {26'h0, ctrl_r};
            rplk_pkg::A_ADDR: dat_nxt = {27'h0, bus_addr_o};
            rplk_pkg::A_RX:   dat_nxt = {24'h0, rx_dat_r};
            rplk_pkg::A_STAT: dat_nxt = {21'h0, stat};
            rplk_pkg::A_CAPS: dat_nxt = {22'h0, rplk_pkg::CAPS_VAL};
            default:          dat_nxt = 32'h0000_0000;
         endcase
      end
      if (wr && wb_adr_i == rplk_pkg::A_CTRL) ctrl_nxt = wd[5:0];
      if (wr && wb_adr_i == rplk_pkg::A_ADDR) addr_nxt = wd[4:0];
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
         ctrl_r <= rplk_pkg::CTRL_RST;
         bus_addr_o <= rplk_pkg::ADDR_RST;
      end else begin
         wb_ack_o <= ack_nxt;
         wb_dat_o <= dat_nxt;
         ctrl_r <= ctrl_nxt;
         bus_addr_o <= addr_nxt;
      end
   end

   // ---------------------------------------------------------------
   // 16x oversample tick from the selected rate
   // ---------------------------------------------------------------
   always_comb begin
      case (ctrl_r[rplk_pkg::C_BAUD +: 2])
         2'h0:    div_max = 16'(DIV_1200 - 1);
         2'h1:    div_max = 16'(DIV_2400 - 1);
         2'h2:    div_max = 16'(DIV_9600 - 1);
         default: div_max = 16'(DIV_19200 - 1);
      endcase
      tick_nxt = div_cnt_r >= div_max;
      div_cnt_nxt = tick_nxt ? 16'h0000 : div_cnt_r + 16'h0001;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div_cnt_r <= 16'h0000;
         tick_r <= 1'b0;
      end else begin
         div_cnt_r <= div_cnt_nxt;
         tick_r <= tick_nxt;
      end
   end

   // ---------------------------------------------------------------
   // transmitter; a char waits in the hold register while paused
   // ---------------------------------------------------------------
   always_comb begin
      tx_st_nxt = tx_st_r;
      tx_sub_nxt = tx_sub_r;
      tx_bit_nxt = tx_bit_r;
      tx_sh_nxt = tx_sh_r;
      tx_par_nxt = tx_par_r;
      tx_stop_nxt = tx_stop_r;
      tx_hold_nxt = tx_hold_r;
      tx_full_nxt = tx_full_r;
      txd_nxt = txd_o;
      if (wr && wb_adr_i == rplk_pkg::A_TX && !tx_full_r) begin
         tx_hold_nxt = wd;
         tx_full_nxt = 1'b1;
      end
      case (tx_st_r)
         rplk_pkg::ST_IDLE: begin
            txd_nxt = 1'b1;
            if (tx_full_r && !pause_r && tick_r) begin
               tx_st_nxt = rplk_pkg::ST_START;
               tx_sh_nxt = tx_hold_r;
               tx_par_nxt = rplk_pkg::rplk_par(tx_hold_r,
                  ctrl_r[rplk_pkg::C_EIGHT],
                  ctrl_r[rplk_pkg::C_PAR +: 2] == rplk_pkg::PAR_ODD);
               tx_full_nxt = 1'b0;
               tx_sub_nxt = 4'h0;
               tx_bit_nxt = 3'h0;
               tx_stop_nxt = 1'b0;
               txd_nxt = 1'b0;
            end
         end
         rplk_pkg::ST_START, rplk_pkg::ST_DATA, rplk_pkg::ST_PAR,
         rplk_pkg::ST_STOP: begin
            if (tick_r) begin
               tx_sub_nxt = tx_sub_r + 4'h1;
               if (tx_sub_r == 4'hf) begin
                  case (tx_st_r)
                     rplk_pkg::ST_START: begin
                        tx_st_nxt = rplk_pkg::ST_DATA;
                        txd_nxt = tx_sh_r[0];
                     end
                     rplk_pkg::ST_DATA: begin
                        tx_sh_nxt = {1'b0, tx_sh_r[7:1]};
                        tx_bit_nxt = tx_bit_r + 3'h1;
                        txd_nxt = tx_sh_r[1];
                        if (tx_bit_r == (ctrl_r[rplk_pkg::C_EIGHT] ?
                                         3'h7 : 3'h6)) begin
                           if (ctrl_r[rplk_pkg::C_PAR +: 2] ==
                               rplk_pkg::PAR_NONE) begin
                              tx_st_nxt = rplk_pkg::ST_STOP;
                              txd_nxt = 1'b1;
                           end else begin
                              tx_st_nxt = rplk_pkg::ST_PAR;
                              txd_nxt = tx_par_r;
                           end
                        end
                     end
                     rplk_pkg::ST_PAR: begin
                        tx_st_nxt = rplk_pkg::ST_STOP;
                        txd_nxt = 1'b1;
                     end
                     default: begin
                        if (ctrl_r[rplk_pkg::C_TWO] && !tx_stop_r)
                           tx_stop_nxt = 1'b1;
                        else
                           tx_st_nxt = rplk_pkg::ST_IDLE;
                     end
                  endcase
               end
            end
         end
         default: tx_st_nxt = rplk_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_st_r <= rplk_pkg::ST_IDLE;
         tx_sub_r <= 4'h0;
         tx_bit_r <= 3'h0;
         tx_sh_r <= 8'h00;
         tx_par_r <= 1'b0;
         tx_stop_r <= 1'b0;
         tx_hold_r <= 8'h00;
         tx_full_r <= 1'b0;
         txd_o <= 1'b1;
      end else begin
         tx_st_r <= tx_st_nxt;
         tx_sub_r <= tx_sub_nxt;
         tx_bit_r <= tx_bit_nxt;
         tx_sh_r <= tx_sh_nxt;
         tx_par_r <= tx_par_nxt;
         tx_stop_r <= tx_stop_nxt;
         tx_hold_r <= tx_hold_nxt;
         tx_full_r <= tx_full_nxt;
         txd_o <= txd_nxt;
      end
   end

   // ---------------------------------------------------------------
   // receiver and character filter
   // ---------------------------------------------------------------
   rplk_rx u_rx (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .tick_i  (tick_r),
      .rxd_i   (rxd_i),
      .eight_i (ctrl_r[rplk_pkg::C_EIGHT]),
      .par_i   (ctrl_r[rplk_pkg::C_PAR +: 2]),
      .data_o  (rx_byte),
      .vld_o   (rx_vld),
      .perr_o  (rx_perr),
      .ferr_o  (rx_ferr)
   );

   assign rx_chr = rx_byte & (ctrl_r[rplk_pkg::C_EIGHT] ? 8'hff : 8'h7f);
   assign is_ctl = rx_chr < rplk_pkg::CH_SP || rx_chr == rplk_pkg::CH_DEL;

   // ---------------------------------------------------------------
   // status flags and panel lockout; hardware set beats clear
   // ---------------------------------------------------------------
   always_comb begin
      rx_dat_nxt = rx_dat_r;
      rxv_nxt = rxv_r;
      lf_nxt = lf_r;
      pause_nxt = pause_r;
      ovr_nxt = ovr_r;
      perr_nxt = perr_r | rx_perr;
      ferr_nxt = ferr_r | rx_ferr;
      llo_nxt = llo_r;
      klk_nxt = klk_r;
      doff_nxt = doff_r;
      if (rd && wb_adr_i == rplk_pkg::A_RX) rxv_nxt = 1'b0;
      if (wr && wb_adr_i == rplk_pkg::A_STAT) begin
         if (wd[rplk_pkg::S_LF]) lf_nxt = 1'b0;
         if (wd[rplk_pkg::S_OVR]) ovr_nxt = 1'b0;
         if (wd[rplk_pkg::S_PERR]) perr_nxt = rx_perr;
         if (wd[rplk_pkg::S_FERR]) ferr_nxt = rx_ferr;
      end
      if (rx_vld) begin
         if (rx_chr == rplk_pkg::CH_XOFF) pause_nxt = 1'b1;
         else if (rx_chr == rplk_pkg::CH_XON) pause_nxt = 1'b0;
         else if (rx_chr == rplk_pkg::CH_LF || !is_ctl) begin
            rx_dat_nxt = rx_chr;
            if (rxv_r && !(rd && wb_adr_i == rplk_pkg::A_RX))
               ovr_nxt = 1'b1;
            rxv_nxt = 1'b1;
            if (rx_chr == rplk_pkg::CH_LF) lf_nxt = 1'b1;
         end
      end
      // bus lockout only from bus messages, never the serial path
      if (bus_gtl_i || !bus_ren_i) llo_nxt = 1'b0;
      if (bus_llo_i) llo_nxt = 1'b1;
      if (wr && wb_adr_i == rplk_pkg::A_LOCK) begin
         if (wd[rplk_pkg::L_KOFF]) klk_nxt = 1'b0;
         if (wd[rplk_pkg::L_KON]) klk_nxt = 1'b1;
         if (wd[rplk_pkg::L_DON]) doff_nxt = 1'b0;
         if (wd[rplk_pkg::L_DOFF] || wd[rplk_pkg::L_DTXT])
            doff_nxt = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_dat_r <= 8'h00;
         rxv_r <= 1'b0;
         lf_r <= 1'b0;
         pause_r <= 1'b0;
         ovr_r <= 1'b0;
         perr_r <= 1'b0;
         ferr_r <= 1'b0;
         llo_r <= 1'b0;
         klk_r <= 1'b0;
         doff_r <= 1'b0;
         kbd_lock_o <= 1'b0;
         disp_blank_o <= 1'b0;
         rts_o <= 1'b0;
      end else begin
         rx_dat_r <= rx_dat_nxt;
         rxv_r <= rxv_nxt;
         lf_r <= lf_nxt;
         pause_r <= pause_nxt;
         ovr_r <= ovr_nxt;
         perr_r <= perr_nxt;
         ferr_r <= ferr_nxt;
         llo_r <= llo_nxt;
         klk_r <= klk_nxt;
         doff_r <= doff_nxt;
         // remote state itself never enters this term
         kbd_lock_o <= llo_nxt | klk_nxt | doff_nxt;
         disp_blank_o <= doff_nxt;
         rts_o <= ~rxv_nxt;
      end
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   property p_kbd_or;
      @(posedge clk_i) disable iff (rst_i)
      kbd_lock_o == (llo_r | klk_r | doff_r);
   endproperty
   a_kbd_or: assert property (p_kbd_or) else $error("lock not or");
   property p_llo_set;
      @(posedge clk_i) disable iff (rst_i) bus_llo_i |=> llo_r && kbd_lock_o;
   endproperty
   a_llo_set: assert property (p_llo_set) else $error("llo missed");
   property p_llo_clr;
      @(posedge clk_i) disable iff (rst_i)
      (bus_gtl_i || !bus_ren_i) && !bus_llo_i |=> !llo_r;
   endproperty
   a_llo_clr: assert property (p_llo_clr) else $error("llo stuck");
   property p_klk_on;
      @(posedge clk_i) disable iff (rst_i)
      wr && wb_adr_i == rplk_pkg::A_LOCK && wd[rplk_pkg::L_KON]
      |=> klk_r && kbd_lock_o;
   endproperty
   a_klk_on: assert property (p_klk_on) else $error("klock on");
   property p_doff;
      @(posedge clk_i) disable iff (rst_i)
      wr && wb_adr_i == rplk_pkg::A_LOCK &&
      (wd[rplk_pkg::L_DOFF] || wd[rplk_pkg::L_DTXT])
      |=> disp_blank_o && kbd_lock_o;
   endproperty
   a_doff: assert property (p_doff) else $error("display off");
   property p_don;
      @(posedge clk_i) disable iff (rst_i)
      wr && wb_adr_i == rplk_pkg::A_LOCK && wd[rplk_pkg::L_DON] &&
      !wd[rplk_pkg::L_DOFF] && !wd[rplk_pkg::L_DTXT] |=> !disp_blank_o;
   endproperty
   a_don: assert property (p_don) else $error("display on");
   property p_pwrup;
      @(posedge clk_i) rst_i |=> !kbd_lock_o && !disp_blank_o && !llo_r;
   endproperty
   a_pwrup: assert property (p_pwrup) else $error("not local");
   property p_xoff;
      @(posedge clk_i) disable iff (rst_i)
      pause_r && tx_st_r == rplk_pkg::ST_IDLE
      |=> tx_st_r == rplk_pkg::ST_IDLE;
   endproperty
   a_xoff: assert property (p_xoff) else $error("tx not paused");
   property p_ctl;
      @(posedge clk_i) disable iff (rst_i)
      rx_vld && is_ctl && rx_chr != rplk_pkg::CH_LF && !rxv_r |=> !rxv_r;
   endproperty
   a_ctl: assert property (p_ctl) else $error("control kept");
   property p_lf;
      @(posedge clk_i) disable iff (rst_i)
      rx_vld && rx_chr == rplk_pkg::CH_LF |=> lf_r && rxv_r;
   endproperty
   a_lf: assert property (p_lf) else $error("lf missed");
   c_llo: cover property (@(posedge clk_i) bus_llo_i ##1 kbd_lock_o);
   c_lf: cover property (@(posedge clk_i) rx_vld && rx_chr == rplk_pkg::CH_LF);
   c_pause: cover property (@(posedge clk_i) pause_r && tx_full_r);
endmodule // rplk_top

// file: verification/rplk_host.sv
`timescale 1ns/1ps
module rplk_host #(
   parameter int BIT = 32
) (
   input  wire logic clk_i, // core clock
   input  wire logic txd_i, // device transmit pin
   output logic      rxd_o  // device receive pin
);
   // line idles at mark level between frames
   initial rxd_o = 1'b1;
   // host set to the device's reset framing, 8n1
   task automatic send(input logic [7:0] c);
      logic [9:0] f;
      f = {1'b1, c, 1'b0};
      for (int i = 0; i < 10; i++) begin
         rxd_o <= f[i]; // lsb first after start bit
         repeat (BIT) @(posedge clk_i);
      end
   endtask
   task automatic take(output logic [7:0] c);
      wait (txd_i === 1'b0);
      repeat (BIT + BIT / 2) @(posedge clk_i);
      for (int i = 0; i < 8; i++) begin
         c[i] = txd_i;
         repeat (BIT) @(posedge clk_i);
      end
   endtask
endmodule // rplk_host

// file: verification/test_remote_port_and_panel_lockout.sv
`timescale 1ns/1ps
module test_remote_port_and_panel_lockout;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0]  adr = 8'h00, c, got;
   logic [31:0] wdat = 32'h0, rdat, seed = 32'hf6d2;
   logic ack, txd, rxd, rts, llo = 1'b0, gtl = 1'b0, ren = 1'b1, klk, dblk;
   logic [4:0]  baddr;
   logic [3:0]  sel = 4'hf;
   logic [31:0] exp_q[$];
   int bad_count = 0, checks_done = 0, cyc_n = 0;
   always #2 clk_i = ~clk_i;
   rplk_top #(.DIV_1200(2), .DIV_2400(2), .DIV_9600(2), .DIV_19200(2)) i_dut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .rxd_i(rxd), .txd_o(txd),
      .rts_o(rts), .bus_llo_i(llo), .bus_gtl_i(gtl), .bus_ren_i(ren),
      .bus_addr_o(baddr), .kbd_lock_o(klk), .disp_blank_o(dblk));
   rplk_host i_host (.clk_i(clk_i), .txd_i(txd), .rxd_o(rxd));
   function automatic logic [31:0] xs(input logic [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      v ^= v << 5;
      return v;
   endfunction
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, s);
      checks_done++;
      if (s !== e) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do @(posedge clk_i); while (ack !== 1'b1);
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      wb(1'b0, a, 32'h0);
   endtask
   task automatic pulse(input int k);
      if (k == 0) llo <= 1'b1;
      else gtl <= 1'b1;
      @(posedge clk_i);
      llo <= 1'b0;
      gtl <= 1'b0;
      repeat (2) @(posedge clk_i);
   endtask
   // scoreboard: oldest noted read value against data seen with ack
   always @(posedge clk_i)
      if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0)
         chk("read", exp_q.pop_front(), rdat);
   always @(posedge clk_i) begin
      cyc_n++;
      if (cyc_n == 40000) begin
         bad_count++;
         complete_run();
      end
   end
   initial begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk("lock", 32'h0, {31'h0, klk | dblk});
      rd(rplk_pkg::A_CTRL, 32'h6);
      rd(rplk_pkg::A_CAPS, 32'h7f);
      rd(8'hfc, 32'h0);
      seed = xs(seed);
      wb(1'b1, rplk_pkg::A_ADDR, {27'h0, seed[4:0]});
      rd(rplk_pkg::A_ADDR, {27'h0, seed[4:0]});
      chk("addr", {27'h0, seed[4:0]}, {27'h0, baddr});
      // write without the low byte lane must leave the address alone
      sel <= 4'he;
      wb(1'b1, rplk_pkg::A_ADDR, {27'h0, ~seed[4:0]});
      sel <= 4'hf;
      chk("sel", {27'h0, seed[4:0]}, {27'h0, baddr});
      $display("test registers done");
      chk("remote", 32'h0, {31'h0, klk});
      pulse(0);
      chk("llo", 32'h1, {31'h0, klk});
      pulse(1);
      chk("gtl", 32'h0, {31'h0, klk});
      pulse(0);
      ren <= 1'b0;
      repeat (2) @(posedge clk_i);
      chk("ren", 32'h0, {31'h0, klk});
      ren <= 1'b1;
      wb(1'b1, rplk_pkg::A_LOCK, 32'h1);
      pulse(0);
      pulse(1);
      chk("klock", 32'h1, {31'h0, klk});
      wb(1'b1, rplk_pkg::A_LOCK, 32'h2);
      chk("kunl", 32'h0, {31'h0, klk});
      for (int i = 2; i < 4; i++) begin
         wb(1'b1, rplk_pkg::A_LOCK, 32'h1 << i);
         chk("doff", 32'h3, {30'h0, dblk, klk});
         wb(1'b1, rplk_pkg::A_LOCK, 32'h10);
         chk("don", 32'h0, {30'h0, dblk, klk});
      end
      wb(1'b1, rplk_pkg::A_LOCK, 32'h5);
      pulse(0);
      rst_i <= 1'b1;
      @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk("pwr", 32'h0, {30'h0, dblk, klk});
      $display("test lockout done");
      seed = xs(seed);
      c = 8'h41 + {3'h0, seed[4:0]};
      // control char first, while the rx register is still empty
      i_host.send(8'h0d);
      i_host.send(c);
      chk("rts", 32'h0, {31'h0, rts});
      rd(rplk_pkg::A_RX, {24'h0, c});
      chk("rts", 32'h1, {31'h0, rts});
      i_host.send(rplk_pkg::CH_LF);
      i_host.send(rplk_pkg::CH_XOFF);
      wb(1'b1, rplk_pkg::A_TX, {24'h0, ~c});
      repeat (400) @(posedge clk_i);
      chk("pause", 32'h1, {31'h0, txd});
      // full, rx valid, lf seen, paused; serial never sets bus lockout
      rd(rplk_pkg::A_STAT, 32'hf);
      // listen from before the start bit, which follows the xon closely
      fork
         i_host.send(rplk_pkg::CH_XON);
         i_host.take(got);
      join
      chk("tx", {24'h0, ~c}, {24'h0, got});
      $display("test serial done");
      repeat (4) @(posedge clk_i);
      complete_run();
   end
endmodule // test_remote_port_and_panel_lockout
